// ==== hdl/pll_lock_detect_vco_cal_control.sv ====
`timescale 1ns/1ps
`include "pll_cal_defs.svh"
module pll_lock_detect_vco_cal_control #(
  parameter logic [15:0] CAL_CYCLES = `CAL_CYCLES_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic ref_clk_tick_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic update_in,
  output pll_cal_pkg::cal_status_t status_out,
  output logic [7:0] ctrl_active_out,
  output logic [7:0] ctrl_buffer_out
);
  import pll_cal_pkg::*;

  // ----------------------------------------
  // state layout
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] buf_reg;
    logic [7:0] act_reg;
    logic [3:0] div_cnt;
    logic [15:0] cal_cnt;
    cal_state_t st;
    cal_status_t stat;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam cal_status_t STAT_RESET = '{
    lock_detect_en: `LOCK_DET_EN_RESET,
    cal_clk: `CAL_CLK_RESET,
    cal_busy: `CAL_BUSY_RESET,
    cal_done: `CAL_DONE_RESET
  };

  localparam state_t STATE_RESET = '{
    buf_reg: `CTRL_RESET,
    act_reg: `CTRL_RESET,
    div_cnt: `DIV_CNT_CLEAR,
    cal_cnt: `CAL_CNT_CLEAR,
    st: cal_idle,
    stat: STAT_RESET
  };

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  // divider field of a control byte
  function automatic logic [1:0] div_sel(input logic [7:0] ctrl);
    div_sel = ctrl[`CAL_DIV_HI:`CAL_DIV_LO];
  endfunction

  // calibrate-now bit of a control byte
  function automatic logic cal_now(input logic [7:0] ctrl);
    cal_now = ctrl[`CAL_NOW_BIT];
  endfunction

  // lock detect disable bit of a control byte
  function automatic logic lock_off(input logic [7:0] ctrl);
    lock_off = ctrl[`LOCK_DET_OFF_BIT];
  endfunction

  // ----------------------------------------
  // divider helpers
  // ----------------------------------------
  // last count of a half period per divider code
  function automatic logic [3:0] div_terminal(input logic [1:0] sel);
    unique case (sel)
      `CAL_DIV_SEL_2: div_terminal = `CAL_DIV2_TERM;
      `CAL_DIV_SEL_4: div_terminal = `CAL_DIV4_TERM;
      `CAL_DIV_SEL_8: div_terminal = `CAL_DIV8_TERM;
      `CAL_DIV_SEL_16: div_terminal = `CAL_DIV16_TERM;
    endcase
  endfunction

  // half period ends on this tick
  function automatic logic half_end(
    input logic tick,
    input logic [3:0] cnt,
    input logic [3:0] term
  );
    half_end = tick & (cnt >= term);
  endfunction

  // divider count after this cycle
  function automatic logic [3:0] div_count_next(
    input logic tick,
    input logic wrap,
    input logic [3:0] cnt
  );
    if (!tick) begin
      div_count_next = cnt;
    end else if (wrap) begin
      div_count_next = `DIV_CNT_CLEAR;
    end else begin
      div_count_next = cnt + `DIV_CNT_STEP;
    end
  endfunction

  // ----------------------------------------
  // calibration helpers
  // ----------------------------------------
  // calibrate-now goes low to high
  function automatic logic cal_rise(
    input logic [7:0] old_ctrl,
    input logic [7:0] new_ctrl
  );
    cal_rise = ~cal_now(old_ctrl) & cal_now(new_ctrl);
  endfunction

  // one full calibration clock period ends
  function automatic logic period_end(
    input logic wrap,
    input logic clk_level
  );
    period_end = wrap & clk_level;
  endfunction

  // last calibration clock period reached
  function automatic logic cal_last(input logic [15:0] cnt);
    cal_last = (cnt >= CAL_CYCLES - `CAL_CNT_STEP);
  endfunction

  // flags decoded from the sequencer state
  function automatic logic is_busy(input cal_state_t st);
    is_busy = (st == cal_run);
  endfunction

  function automatic logic is_done(input cal_state_t st);
    is_done = (st == cal_done);
  endfunction

  // ----------------------------------------
  // active register selection
  // ----------------------------------------
  function automatic logic [7:0] act_next(
    input logic upd,
    input logic wr,
    input logic [7:0] data,
    input logic [7:0] buf_val,
    input logic [7:0] act_val
  );
    if (!upd) begin
      act_next = act_val;
    end else if (wr) begin
      act_next = data;
    end else begin
      act_next = buf_val;
    end
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [3:0] term;
    logic wrap;
    logic cal_edge;
    term = div_terminal(div_sel(s_reg.act_reg));
    wrap = half_end(ref_clk_tick_in, s_reg.div_cnt, term);
    cal_edge = 1'h0;
    s_next = s_reg;

    // buffer and active registers
    if (wr_en_in) begin
      s_next.buf_reg = wr_data_in;
    end
    s_next.act_reg = act_next(update_in, wr_en_in, wr_data_in, s_reg.buf_reg, s_reg.act_reg);
    cal_edge = cal_rise(s_reg.act_reg, s_next.act_reg);

    // lock detect enable
    s_next.stat.lock_detect_en = ~lock_off(s_reg.act_reg);

    // calibration clock divider
    s_next.div_cnt = div_count_next(ref_clk_tick_in, wrap, s_reg.div_cnt);
    if (wrap) begin
      s_next.stat.cal_clk = ~s_reg.stat.cal_clk;
    end

    // calibration sequencer
    unique case (s_reg.st)
      cal_idle, cal_done: begin
        if (cal_edge) begin
          s_next.st = cal_run;
          s_next.cal_cnt = `CAL_CNT_CLEAR;
        end
      end
      cal_run: begin
        if (period_end(wrap, s_reg.stat.cal_clk)) begin
          if (cal_last(s_reg.cal_cnt)) begin
            s_next.st = cal_done;
          end else begin
            s_next.cal_cnt = s_reg.cal_cnt + `CAL_CNT_STEP;
          end
        end
      end
      default: begin
        s_next.st = cal_idle;
      end
    endcase

    // status flags follow the sequencer
    s_next.stat.cal_busy = is_busy(s_next.st);
    s_next.stat.cal_done = is_done(s_next.st);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign status_out = s_reg.stat;
  assign ctrl_active_out = s_reg.act_reg;
  assign ctrl_buffer_out = s_reg.buf_reg;
endmodule

// ==== pkg/pll_cal_defs.svh ====
// Overview of operation
// - lock detect runs unless disable bit 3 set
// - calibration clock is reference divided down
// - bits [2:1] select divide 2,4,8,16
// - ratio 16 works always, longest calibration
// - calibration starts on active bit 0 rising
`ifndef PLL_CAL_DEFS_SVH
`define PLL_CAL_DEFS_SVH
`define CTRL_RESET 8'h06
`define LOCK_DET_OFF_BIT 3
`define CAL_DIV_HI 2
`define CAL_DIV_LO 1
`define CAL_NOW_BIT 0
`define CAL_DIV_SEL_2 2'h0
`define CAL_DIV_SEL_4 2'h1
`define CAL_DIV_SEL_8 2'h2
`define CAL_DIV_SEL_16 2'h3
`define CAL_DIV2_TERM 4'h0
`define CAL_DIV4_TERM 4'h1
`define CAL_DIV8_TERM 4'h3
`define CAL_DIV16_TERM 4'h7
`define DIV_CNT_CLEAR 4'h0
`define DIV_CNT_STEP 4'h1
`define CAL_CNT_CLEAR 16'h0000
`define CAL_CNT_STEP 16'h0001
`define CAL_CYCLES_DEFAULT 16'h0400
`define LOCK_DET_EN_RESET 1'h1
`define CAL_CLK_RESET 1'h0
`define CAL_BUSY_RESET 1'h0
`define CAL_DONE_RESET 1'h0
`endif

// ==== pkg/pll_cal_pkg.sv ====
package pll_cal_pkg;
  typedef enum logic [1:0] {
    cal_idle = 2'h0,
    cal_run = 2'h1,
    cal_done = 2'h3
  } cal_state_t;
  typedef struct packed {
    logic lock_detect_en;
    logic cal_clk;
    logic cal_busy;
    logic cal_done;
  } cal_status_t;
endpackage

// ==== verification/pll_cal_monitor.sv ====
`timescale 1ns/1ps
module pll_cal_monitor (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic ref_clk_tick_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic update_in,
  input wire pll_cal_pkg::cal_status_t status_out,
  input wire logic [7:0] ctrl_active_out,
  input wire logic [7:0] ctrl_buffer_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_ld; status_out.lock_detect_en == !$past(ctrl_active_out[3]); endproperty
  a_ld: assert property (p_ld) else $error("ld");
  property p_ck; $changed(status_out.cal_clk) |-> $past(ref_clk_tick_in); endproperty
  a_ck: assert property (p_ck) else $error("ck");
  property p_go; $rose(ctrl_active_out[0]) && !$past(status_out.cal_busy) |-> status_out.cal_busy; endproperty
  a_go: assert property (p_go) else $error("go");
  property p_bz; $rose(status_out.cal_busy) |-> $past(update_in); endproperty
  a_bz: assert property (p_bz) else $error("bz");
  property p_wr; wr_en_in |=> ctrl_buffer_out == $past(wr_data_in); endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_up; !update_in |=> $stable(ctrl_active_out); endproperty
  a_up: assert property (p_up) else $error("up");
  property p_dn; $fell(status_out.cal_busy) |-> status_out.cal_done; endproperty
  a_dn: assert property (p_dn) else $error("dn");
  c_dn: cover property ($rose(status_out.cal_done));
  c_ld: cover property ($fell(status_out.lock_detect_en));
  c_wu: cover property (wr_en_in && update_in);
endmodule

// ==== verification/test_pll_lock_detect_vco_cal_control.sv ====
`timescale 1ns/1ps
module test_pll_lock_detect_vco_cal_control;
  import pll_cal_pkg::*;
  logic c = 1'h0, r = 1'h0, t = 1'h0, w = 1'h0, u = 1'h0, q;
  logic [7:0] d = 8'h00, a, b;
  cal_status_t s;
  int err_count = 0, n_tests = 0, n;
  always #4 c = ~c;
  always @(posedge c) t <= ~t;
  pll_lock_detect_vco_cal_control #(.CAL_CYCLES(16'h0004)) i_pll_lock_detect_vco_cal_control (.core_clk_in(c),
    .rst_b_in(r), .ref_clk_tick_in(t), .wr_en_in(w), .wr_data_in(d), .update_in(u), .status_out(s),
    .ctrl_active_out(a), .ctrl_buffer_out(b));
  task chk(string m, logic [7:0] g, logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", m, e, g);
    end
  endtask
  task put(logic [7:0] v, logic x);
    @(posedge c);
    w <= 1'b1;
    d <= v;
    u <= x;
    @(posedge c);
    w <= 1'b0;
    u <= 1'b0;
    @(negedge c);
  endtask
  task upd;
    @(posedge c);
    u <= 1'h1;
    @(posedge c);
    u <= 1'h0;
    @(negedge c);
  endtask
  task end_sim;
    $display("%0d checks %0d bad", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #50us;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge c);
    r <= 1'h1;
    @(negedge c);
    chk("rst buf", b, 8'h06);
    chk("rst act", a, 8'h06);
    chk("rst stat", {4'h0, s}, 8'h08);
    $display("reset test done");
    put(8'h09, 1'h0);
    chk("buf", b, 8'h09);
    chk("act", a, 8'h06);
    chk("early", {7'h00, s.cal_busy}, 8'h00);
    put(8'h08, 1'h0);
    upd;
    chk("upd", a, 8'h08);
    @(negedge c);
    chk("ld", {7'h00, s.lock_detect_en}, 8'h00);
    $display("register test done");
    for (int k = 0; k < 4; k++) begin
      put(8'(2 * k), 1'h1);
      chk("nf", {7'h00, s.cal_busy}, 8'h00);
      put(8'(2 * k + 1), 1'h1);
      chk("bz", {7'h00, s.cal_busy}, 8'h01);
      chk("ld on", {7'h00, s.lock_detect_en}, 8'h01);
      q = s.cal_clk;
      n = 0;
      while (s.cal_clk === q) @(negedge c);
      q = s.cal_clk;
      while (s.cal_clk === q && n < 40) begin
        @(negedge c);
        n++;
      end
      chk("div", 8'(n), 8'(2 << k));
      repeat (160) @(negedge c);
      chk("dn", {6'h00, s.cal_busy, s.cal_done}, 8'h01);
      $display("ratio %0d test done", 2 << k);
    end
    put(8'h07, 1'h1);
    chk("re", {7'h00, s.cal_busy}, 8'h00);
    $display("restart test done");
    end_sim;
  end
endmodule
bind pll_lock_detect_vco_cal_control pll_cal_monitor i_pll_cal_monitor (.core_clk_in(core_clk_in),
  .rst_b_in(rst_b_in), .ref_clk_tick_in(ref_clk_tick_in), .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
  .update_in(update_in), .status_out(status_out), .ctrl_active_out(ctrl_active_out),
  .ctrl_buffer_out(ctrl_buffer_out));
